// [src/fdm_ctrl.v]
/*
  Control register bank and digital modulator core of the fractional-N
  divider. Assumes the serial port delivers one write strobe per register
  word, on MCLK, and that reads are served combinationally from the bank.
*/
`timescale 1ns/1ns
`include "fdm_regs.vh"

// What this block does
// - Force enable drives pump continuously up or down, overriding the detector.
// - Hold 4-bit up and down gain trims, reset zero, to analog pump.
// - Hold up leak code reset 4h and down leak code reset zero.
// - Hold 2-bit amplifier bias code resetting to 2h.
// - Five reserved 24-bit read/write registers keep written values, documented resets.
// - Hold 16-bit integer divide word resetting to C8h.
// - Hold 24-bit fractional word resetting to zero and feed the modulator.
// - 24-bit seed sets accumulator start phase; software picks random seeds.
// - Autoseed loads seed into accumulators when fraction word is written while modulator runs.
// - Integer mode divides by integer word only; modulator keeps running.
// - Order field selects first, second, third feedback or third feedforward.
// - Quantizer output clamped to signed maximum field, reset 3h.
// - Quantizer output clamped to signed minimum field, reset Ch.
// - Reference-clock select bit moves modulator clock to reference.
// - Bits invert modulator clock and reference clock phase.
// - Sine-source select chooses sine reference when reference clocks modulator.
// - Modulator reset-release input holds modulator in reset when low.
module fdm_ctrl (
  input  wire        MCLK,
  input  wire        RST,
  input  wire        WR_STB,
  input  wire [4:0]  WR_ADDR,
  input  wire [23:0] WR_DATA,
  input  wire [4:0]  RD_ADDR,
  output reg  [23:0] RD_DATA,
  input  wire        PFD_UP,
  input  wire        PFD_DN,
  input  wire        MOD_RUN,
  output reg         PUMP_UP,
  output reg         PUMP_DN,
  output reg  [3:0]  PUMP_UP_GAIN_TRIM,
  output reg  [3:0]  PUMP_DOWN_GAIN_TRIM,
  output reg  [3:0]  PUMP_UP_LEAK_CODE,
  output reg  [3:0]  PUMP_DOWN_LEAK_CODE,
  output reg  [1:0]  PUMP_AMP_BIAS_CODE,
  output reg         MOD_CLK_FROM_REF,
  output reg         MODULATOR_CLOCK_INVERT,
  output reg         REF_PHASE_INVERT,
  output reg         REF_SINE_SELECT,
  output reg  [15:0] DIVIDE_VALUE
);

  // ********************************************************************
  // Register bank
  // ********************************************************************
  reg  [17:0] trim_r;
  reg  [1:0]  force_r;
  reg  [23:0] rsv_r [0:4];
  reg  [15:0] int_r;
  reg  [23:0] frac_r;
  reg  [23:0] seed_r;
  reg  [17:0] cfg_r;
  reg         seed_load_r;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      trim_r      <= `FDM_RST_TRIM;
      force_r     <= `FDM_RST_FORCE;
      rsv_r[0]    <= `FDM_RST_RSV_A;
      rsv_r[1]    <= `FDM_RST_RSV_B;
      rsv_r[2]    <= `FDM_RST_RSV_C;
      rsv_r[3]    <= `FDM_RST_RSV_D;
      rsv_r[4]    <= `FDM_RST_RSV_E;
      int_r       <= `FDM_RST_INT;
      frac_r      <= `FDM_RST_FRAC;
      seed_r      <= `FDM_RST_SEED;
      cfg_r       <= `FDM_RST_CFG;
      seed_load_r <= 1'b0;
    end else begin
      seed_load_r <= 1'b0;
      if (WR_STB) begin
        case (WR_ADDR)
          `FDM_A_TRIM:  trim_r  <= WR_DATA[17:0];
          `FDM_A_FORCE: force_r <= WR_DATA[1:0];
          `FDM_A_RSV_A: rsv_r[0] <= WR_DATA;
          `FDM_A_RSV_B: rsv_r[1] <= WR_DATA;
          `FDM_A_RSV_C: rsv_r[2] <= WR_DATA;
          `FDM_A_RSV_D: rsv_r[3] <= WR_DATA;
          `FDM_A_RSV_E: rsv_r[4] <= WR_DATA;
          `FDM_A_INT:   int_r   <= WR_DATA[15:0];
          `FDM_A_FRAC: begin
            frac_r      <= WR_DATA;
            seed_load_r <= cfg_r[`FDM_CFG_AUTOSEED];
          end
          `FDM_A_SEED:  seed_r  <= WR_DATA;
          `FDM_A_CFG:   cfg_r   <= WR_DATA[17:0] & `FDM_CFG_RSV_MASK;
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    case (RD_ADDR)
      `FDM_A_TRIM:  RD_DATA = {6'h00, trim_r};
      `FDM_A_FORCE: RD_DATA = {22'h00_0000, force_r};
      `FDM_A_RSV_A: RD_DATA = rsv_r[0];
      `FDM_A_RSV_B: RD_DATA = rsv_r[1];
      `FDM_A_RSV_C: RD_DATA = rsv_r[2];
      `FDM_A_RSV_D: RD_DATA = rsv_r[3];
      `FDM_A_RSV_E: RD_DATA = rsv_r[4];
      `FDM_A_INT:   RD_DATA = {8'h00, int_r};
      `FDM_A_FRAC:  RD_DATA = frac_r;
      `FDM_A_SEED:  RD_DATA = seed_r;
      `FDM_A_CFG:   RD_DATA = {6'h00, cfg_r};
      default:      RD_DATA = 24'h00_0000;
    endcase
  end

  // ********************************************************************
  // Pump and clocking controls
  // ********************************************************************
  // The force path is registered so the pump never sees a decode glitch.
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PUMP_UP                <= 1'b0;
      PUMP_DN                <= 1'b0;
      PUMP_UP_GAIN_TRIM      <= 4'h0;
      PUMP_DOWN_GAIN_TRIM    <= 4'h0;
      PUMP_UP_LEAK_CODE      <= 4'h4;
      PUMP_DOWN_LEAK_CODE    <= 4'h0;
      PUMP_AMP_BIAS_CODE     <= 2'h2;
      MOD_CLK_FROM_REF       <= 1'b0;
      MODULATOR_CLOCK_INVERT <= 1'b1;
      REF_PHASE_INVERT       <= 1'b0;
      REF_SINE_SELECT        <= 1'b0;
    end else begin
      if (force_r[`FDM_FORCE_EN]) begin
        PUMP_UP <= ~force_r[`FDM_FORCE_DIR];
        PUMP_DN <= force_r[`FDM_FORCE_DIR];
      end else begin
        PUMP_UP <= PFD_UP;
        PUMP_DN <= PFD_DN;
      end
      PUMP_UP_GAIN_TRIM      <= trim_r[`FDM_TRIM_UP];
      PUMP_DOWN_GAIN_TRIM    <= trim_r[`FDM_TRIM_DN];
      PUMP_UP_LEAK_CODE      <= trim_r[`FDM_LEAK_UP];
      PUMP_DOWN_LEAK_CODE    <= trim_r[`FDM_LEAK_DN];
      PUMP_AMP_BIAS_CODE     <= trim_r[`FDM_AMP_BIAS];
      MOD_CLK_FROM_REF       <= cfg_r[`FDM_CFG_REFCLK];
      MODULATOR_CLOCK_INVERT <= cfg_r[`FDM_CFG_CLKINV];
      REF_PHASE_INVERT       <= cfg_r[`FDM_CFG_REFINV];
      // Sine select only matters while the reference clocks the modulator.
      REF_SINE_SELECT <= cfg_r[`FDM_CFG_REFCLK] & cfg_r[`FDM_CFG_SINSEL];
    end
  end

  // ********************************************************************
  // Delta-sigma modulator
  // ********************************************************************
  // MOD_RUN arrives from another register domain, so it is filtered.
  reg  [2:0]  run_sync_r;
  reg         run_r;
  reg  [24:0] acc1_r;
  reg  [24:0] acc2_r;
  reg  [24:0] acc3_r;
  reg  [24:0] acc1_nxt;
  reg  [24:0] acc2_nxt;
  reg  [24:0] acc3_nxt;
  reg         c1;
  reg         c2;
  reg         c3;
  reg  [1:0]  c2_d_r;
  reg  [1:0]  c3_d_r;
  reg  signed [4:0] q_raw;
  reg  signed [4:0] q_clip;
  wire signed [4:0] q_max = {cfg_r[`FDM_CFG_QMAX_MSB], cfg_r[`FDM_CFG_QMAX]};
  wire signed [4:0] q_min = {cfg_r[`FDM_CFG_QMIN_MSB], cfg_r[`FDM_CFG_QMIN]};

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_sync_r <= 3'h0;
      run_r      <= 1'b0;
    end else begin
      run_sync_r <= {run_sync_r[1:0], MOD_RUN};
      if (run_sync_r[1] == run_sync_r[2])
        run_r <= run_sync_r[2];
    end
  end

  always @* begin
    acc1_nxt = {1'b0, acc1_r[23:0]} + {1'b0, frac_r};
    acc2_nxt = {1'b0, acc2_r[23:0]} + {1'b0, acc1_nxt[23:0]};
    // Both third-order settings share this stage; only the cancellation differs.
    acc3_nxt = {1'b0, acc3_r[23:0]} + {1'b0, acc2_nxt[23:0]};
    c1 = acc1_nxt[24];
    c2 = acc2_nxt[24];
    c3 = acc3_nxt[24];
    case (cfg_r[`FDM_CFG_ORDER])
      `FDM_ORD_1ST: q_raw = {4'h0, c1};
      `FDM_ORD_2ND: q_raw = $signed({4'h0, c1}) + $signed({4'h0, c2})
                            - $signed({4'h0, c2_d_r[0]});
      `FDM_ORD_3FB: q_raw = $signed({4'h0, c1}) + $signed({4'h0, c2})
                            - $signed({4'h0, c2_d_r[0]}) + $signed({4'h0, c3})
                            - $signed({3'h0, c3_d_r[0], 1'b0})
                            + $signed({4'h0, c3_d_r[1]});
      default:      q_raw = $signed({4'h0, c1}) + $signed({4'h0, c2})
                            - $signed({4'h0, c2_d_r[0]}) + $signed({4'h0, c3})
                            - $signed({4'h0, c3_d_r[0]});
    endcase
    if (q_raw > q_max)
      q_clip = q_max;
    else if (q_raw < q_min)
      q_clip = q_min;
    else
      q_clip = q_raw;
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      acc1_r       <= 25'h000_0000;
      acc2_r       <= 25'h000_0000;
      acc3_r       <= 25'h000_0000;
      c2_d_r       <= 2'h0;
      c3_d_r       <= 2'h0;
      DIVIDE_VALUE <= `FDM_RST_INT;
    end else if (!run_r) begin
      acc1_r       <= 25'h000_0000;
      acc2_r       <= 25'h000_0000;
      acc3_r       <= 25'h000_0000;
      c2_d_r       <= 2'h0;
      c3_d_r       <= 2'h0;
      DIVIDE_VALUE <= int_r;
    end else if (seed_load_r) begin
      acc1_r       <= {1'b0, seed_r};
      acc2_r       <= {1'b0, seed_r};
      acc3_r       <= {1'b0, seed_r};
      c2_d_r       <= 2'h0;
      c3_d_r       <= 2'h0;
      DIVIDE_VALUE <= int_r;
    end else begin
      acc1_r       <= acc1_nxt;
      acc2_r       <= acc2_nxt;
      acc3_r       <= acc3_nxt;
      c2_d_r       <= {c2_d_r[0], c2};
      c3_d_r       <= {c3_d_r[0], c3};
      // Mean of the dither is the fraction over 2^24 on top of the integer.
      if (cfg_r[`FDM_CFG_INTMODE])
        DIVIDE_VALUE <= int_r;
      else
        DIVIDE_VALUE <= int_r + {{11{q_clip[4]}}, q_clip};
    end
  end

endmodule

// [src/fdm_regs.vh]
/*
  Register offsets, field positions and reset values for the fractional-N
  divider and modulator control bank. Assumes a serial-port front end that
  presents a decoded register index, a 24-bit write word and a write strobe.
*/
`ifndef FDM_REGS_VH
`define FDM_REGS_VH

`define FDM_ADDR_W          5
`define FDM_DATA_W          24
`define FDM_A_TRIM          5'h08
`define FDM_A_FORCE         5'h09
`define FDM_A_RSV_A         5'h0A
`define FDM_A_RSV_B         5'h0B
`define FDM_A_RSV_C         5'h0C
`define FDM_A_RSV_D         5'h0D
`define FDM_A_RSV_E         5'h0E
`define FDM_A_INT           5'h0F
`define FDM_A_FRAC          5'h10
`define FDM_A_SEED          5'h11
`define FDM_A_CFG           5'h12

`define FDM_RST_TRIM        18'h2_0400
`define FDM_RST_FORCE       2'h0
`define FDM_RST_RSV_A       24'h00_0304
`define FDM_RST_RSV_B       24'h00_0000
`define FDM_RST_RSV_C       24'h00_0100
`define FDM_RST_RSV_D       24'h00_0020
`define FDM_RST_RSV_E       24'h00_0000
`define FDM_RST_INT         16'h00C8
`define FDM_RST_FRAC        24'h00_0000
`define FDM_RST_SEED        24'h00_0000
`define FDM_RST_CFG         18'h3_0E82

`define FDM_TRIM_UP         3:0
`define FDM_TRIM_DN         7:4
`define FDM_LEAK_UP         11:8
`define FDM_LEAK_DN         15:12
`define FDM_AMP_BIAS        17:16
`define FDM_FORCE_EN        0
`define FDM_FORCE_DIR       1
`define FDM_CFG_REFCLK      0
`define FDM_CFG_CLKINV      1
`define FDM_CFG_REFINV      2
`define FDM_CFG_INTMODE     3
`define FDM_CFG_SINSEL      6
`define FDM_CFG_AUTOSEED    7
`define FDM_CFG_ORDER       9:8
`define FDM_CFG_QMAX        13:10
`define FDM_CFG_QMIN        17:14
`define FDM_CFG_QMAX_MSB    13
`define FDM_CFG_QMIN_MSB    17
`define FDM_CFG_RSV_MASK    18'h3_FFCF

`define FDM_ORD_1ST         2'h0
`define FDM_ORD_2ND         2'h1
`define FDM_ORD_3FB         2'h2
`define FDM_ORD_3FF         2'h3
`define FDM_FRAC_ONE        25'h100_0000

`endif

// [tb/fdm_ctrl_properties.sv]
/* Port checker for fdm_ctrl.
   Assumes one MCLK domain and the bind at the foot of this file. */
`timescale 1ns/1ns
module fdm_chk (
  input wire        MCLK,
  input wire        RST,
  input wire        WR_STB,
  input wire [4:0]  WR_ADDR,
  input wire [23:0] WR_DATA,
  input wire [4:0]  RD_ADDR,
  input wire [23:0] RD_DATA,
  input wire        PUMP_UP,
  input wire        PUMP_DN,
  input wire        MOD_RUN,
  input wire [3:0]  PUMP_UP_GAIN_TRIM,
  input wire [3:0]  PUMP_DOWN_GAIN_TRIM,
  input wire [3:0]  PUMP_UP_LEAK_CODE,
  input wire [3:0]  PUMP_DOWN_LEAK_CODE,
  input wire [1:0]  PUMP_AMP_BIAS_CODE,
  input wire        MOD_CLK_FROM_REF,
  input wire        MODULATOR_CLOCK_INVERT,
  input wire        REF_PHASE_INVERT,
  input wire        REF_SINE_SELECT,
  input wire [15:0] DIVIDE_VALUE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_wr(logic [4:0] a);
    WR_STB && WR_ADDR == a;
  endsequence
  // Eight idle cycles let the run filter settle before the hold is judged.
  sequence s_quiet;
    (!MOD_RUN && !WR_STB)[*8];
  endsequence
  property p_force_up;
    s_wr(5'h09) ##0 WR_DATA[1:0] == 2'b01 |-> ##2 PUMP_UP && !PUMP_DN;
  endproperty
  property p_force_dn;
    s_wr(5'h09) ##0 WR_DATA[1:0] == 2'b11 |-> ##2 !PUMP_UP && PUMP_DN;
  endproperty
  property p_trim;
    s_wr(5'h08) |-> ##2 {PUMP_DOWN_GAIN_TRIM, PUMP_UP_GAIN_TRIM} == $past(WR_DATA[7:0], 2);
  endproperty
  property p_leak;
    s_wr(5'h08) |-> ##2 {PUMP_AMP_BIAS_CODE, PUMP_DOWN_LEAK_CODE, PUMP_UP_LEAK_CODE}
      == $past(WR_DATA[17:8], 2);
  endproperty
  property p_rsv;
    WR_STB && WR_ADDR >= 5'h0A && WR_ADDR <= 5'h0E
      |=> RD_ADDR != $past(WR_ADDR) || RD_DATA == $past(WR_DATA);
  endproperty
  property p_int;
    s_wr(5'h0F) |=> RD_ADDR != 5'h0F || RD_DATA == {8'h00, $past(WR_DATA[15:0])};
  endproperty
  property p_frac;
    s_wr(5'h10) |=> RD_ADDR != 5'h10 || RD_DATA == $past(WR_DATA);
  endproperty
  property p_cfg_rd;
    s_wr(5'h12) |=> RD_ADDR != 5'h12 || RD_DATA == {6'h00, $past(WR_DATA[17:0]) & 18'h3_FFCF};
  endproperty
  property p_cfg_out;
    s_wr(5'h12) |-> ##2 {REF_PHASE_INVERT, MODULATOR_CLOCK_INVERT, MOD_CLK_FROM_REF}
      == $past(WR_DATA[2:0], 2);
  endproperty
  property p_sine;
    s_wr(5'h12) |-> ##2 REF_SINE_SELECT == ($past(WR_DATA[0], 2) & $past(WR_DATA[6], 2));
  endproperty
  property p_hold;
    s_quiet ##0 RD_ADDR == 5'h0F |-> DIVIDE_VALUE == RD_DATA[15:0];
  endproperty
  a_force_up: assert property (p_force_up) else $error("pump not forced up");
  a_force_dn: assert property (p_force_dn) else $error("pump not forced down");
  a_trim: assert property (p_trim) else $error("gain trim outputs wrong");
  a_leak: assert property (p_leak) else $error("leak or bias outputs wrong");
  a_rsv: assert property (p_rsv) else $error("spare word not kept");
  a_int: assert property (p_int) else $error("integer word not kept");
  a_frac: assert property (p_frac) else $error("fraction word not kept");
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  a_cfg_out: assert property (p_cfg_out) else $error("clock controls wrong");
  a_sine: assert property (p_sine) else $error("sine select wrong");
  a_hold: assert property (p_hold) else $error("stopped modulator not integer");
endmodule
bind fdm_ctrl fdm_chk u_chk (.MCLK, .RST, .WR_STB, .WR_ADDR, .WR_DATA, .RD_ADDR, .RD_DATA,
  .PUMP_UP, .PUMP_DN, .MOD_RUN, .PUMP_UP_GAIN_TRIM, .PUMP_DOWN_GAIN_TRIM, .PUMP_UP_LEAK_CODE,
  .PUMP_DOWN_LEAK_CODE, .PUMP_AMP_BIAS_CODE, .MOD_CLK_FROM_REF, .MODULATOR_CLOCK_INVERT,
  .REF_PHASE_INVERT, .REF_SINE_SELECT, .DIVIDE_VALUE);

// [tb/tb_fdm_ctrl.sv]
/* Self-checking bench for fdm_ctrl.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ns
module tb_fdm_ctrl;
  reg          clk = 0;
  reg          rst = 1;
  reg          stb = 0;
  reg  [4:0]   wa = 0;
  reg  [23:0]  wd = 0;
  reg  [4:0]   ra = 0;
  reg          pu_in = 0;
  reg          pd_in = 0;
  reg          mrun = 0;
  wire [23:0]  rd;
  wire         pu, pd, cref, cinv, rinv, sine;
  wire [3:0]   ut, dt, ul, dl;
  wire [1:0]   bias;
  wire [15:0]  div;
  integer      err_count = 0;
  integer      checks = 0;
  integer      a, o, i, s;
  // Reset values and writable bits, 07h and 13h standing for unmapped places.
  reg  [23:0]  rv [7:19] = '{0, 24'h02_0400, 0, 24'h00_0304, 0, 24'h00_0100, 24'h00_0020, 0,
                             24'h00_00C8, 0, 0, 24'h03_0E82, 0};
  reg  [23:0]  mk [7:19] = '{0, 24'h03_FFFF, 3, 24'hFF_FFFF, 24'hFF_FFFF, 24'hFF_FFFF,
                             24'hFF_FFFF, 24'hFF_FFFF, 24'h00_FFFF, 24'hFF_FFFF,
                             24'hFF_FFFF, 24'h03_FFCF, 0};
  fdm_ctrl DUT (.MCLK(clk), .RST(rst), .WR_STB(stb), .WR_ADDR(wa), .WR_DATA(wd), .RD_ADDR(ra),
    .RD_DATA(rd), .PFD_UP(pu_in), .PFD_DN(pd_in), .MOD_RUN(mrun), .PUMP_UP(pu), .PUMP_DN(pd),
    .PUMP_UP_GAIN_TRIM(ut), .PUMP_DOWN_GAIN_TRIM(dt), .PUMP_UP_LEAK_CODE(ul),
    .PUMP_DOWN_LEAK_CODE(dl), .PUMP_AMP_BIAS_CODE(bias), .MOD_CLK_FROM_REF(cref),
    .MODULATOR_CLOCK_INVERT(cinv), .REF_PHASE_INVERT(rinv), .REF_SINE_SELECT(sine),
    .DIVIDE_VALUE(div));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input [23:0] got, input [23:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [4:0] adr, input [23:0] d);
    @(negedge clk);
    stb = 1;
    wa = adr;
    wd = d;
    @(negedge clk);
    stb = 0;
  endtask
  task rd_chk(input [4:0] adr, input [23:0] e);
    @(negedge clk);
    ra = adr;
    #1 chk(rd, e);
  endtask
  task results;
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    for (a = 7; a < 20; a = a + 1) rd_chk(a, rv[a]);
    chk({ut, dt, ul, dl, bias}, 18'h0_0102);
    chk({cref, cinv, rinv, sine, div}, 20'h4_00C8);
  endtask
  task t_rw;
    for (a = 7; a < 20; a = a + 1) begin
      wr(a, 24'h5A_A5C3);
      rd_chk(a, 24'h5A_A5C3 & mk[a]);
      wr(a, 24'hFF_FFFF);
      rd_chk(a, mk[a]);
    end
  endtask
  task t_pump;
    pd_in = 1;
    wr(5'h09, 24'h00_0001);
    @(negedge clk) chk({pu, pd}, 2'b10);
    wr(5'h09, 24'h00_0003);
    @(negedge clk) chk({pu, pd}, 2'b01);
    wr(5'h09, 24'h00_0002);
    pu_in = 1;
    pd_in = 0;
    @(negedge clk) chk({pu, pd}, 2'b10);
  endtask
  task t_fields;
    wr(5'h08, 24'h03_A5C3);
    @(negedge clk) chk({ut, dt, ul, dl, bias}, 18'h0_F16B);
    wr(5'h12, 24'h00_0045);
    @(negedge clk) chk({cref, cinv, rinv, sine}, 4'b1011);
    wr(5'h12, 24'h00_0042);
    @(negedge clk) chk({cref, cinv, rinv, sine}, 4'b0100);
  endtask
  task t_mod;
    mrun = 1;
    wr(5'h0F, 24'h00_0123);
    wr(5'h10, 24'h80_0000);
    wr(5'h12, 24'h03_0E8A);
    repeat (10) @(negedge clk);
    for (i = 0; i < 20; i = i + 1) @(negedge clk) chk(div, 16'h0123);
    for (o = 0; o < 4; o = o + 1) begin
      wr(5'h12, 24'h02_1C82 | (o << 8));
      repeat (16) @(negedge clk);
      s = 0;
      for (i = 0; i < 128; i = i + 1) begin
        @(negedge clk) s = s + div;
        chk(div >= 16'h011B && div <= 16'h012A, 1);
      end
      chk(s >= 37304 && s <= 37320, 1);
    end
    wr(5'h12, 24'h03_0E82);
    repeat (10) @(negedge clk);
    for (i = 0; i < 128; i = i + 1)
      @(negedge clk) chk(div >= 16'h011F && div <= 16'h0126, 1);
    mrun = 0;
    ra = 5'h0F;
    repeat (12) @(negedge clk);
    chk(div, 16'h0123);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_reset;
    t_rw;
    t_pump;
    t_fields;
    t_mod;
    results;
  end
endmodule
